// [shared/rsf_pkg.sv]
package rsf_pkg;

  // ==========================================================================
  // register map and serial word layout
  // ==========================================================================
  localparam logic [7:0] RSF_ADDR_FLAGS = 8'hEA;
  localparam int         RSF_ADDR_BITS  = 8;
  localparam int         RSF_WORD_BITS  = 24;
  localparam int         RSF_INPUTS     = 7;
  localparam int         RSF_GP_BITS    = 4;
  localparam int         RSF_EVENTS     = 5;

  // address bits received once the address phase is complete
  localparam logic [3:0] RSF_ADDR_FULL  = 4'h8;
  // index of the bit on the data pin when the final edge of a word is taken
  localparam logic [4:0] RSF_LAST_SHIFT = 5'h16;
  localparam logic [4:0] RSF_BIT_FIRST  = 5'h00;
  localparam logic [4:0] RSF_BIT_STEP   = 5'h01;

  // ==========================================================================
  // read-to-clear event indices
  // ==========================================================================
  localparam int RSF_EV_IN_CHG = 0;
  localparam int RSF_EV_RATE   = 1;
  localparam int RSF_EV_CS     = 2;
  localparam int RSF_EV_PC     = 3;
  localparam int RSF_EV_GP     = 4;

  // ==========================================================================
  // status word, bit 0 at the bottom
  // ==========================================================================
  typedef struct packed {
    logic [3:0]            zero_hi;
    logic                  sync61_seen;
    logic                  sync51_seen;
    logic                  burst_preamble_seen;
    logic                  pcm_mode_bit;
    logic                  emphasis_flag;
    logic                  parallel_input_update_flag;
    logic                  pc_update_flag;
    logic                  non_pcm_flag;
    logic                  chan_status_update_flag;
    logic                  rate_update_flag;
    logic                  input_change_flag;
    logic                  receive_error_flag;
    logic                  zero_b7;
    logic [RSF_INPUTS-1:0] input_present;
  } rsf_status_type;

  localparam rsf_status_type RSF_STATUS_RESET = 24'h000000;

  typedef enum logic [2:0] {
    RSF_LINK_ADDR = 3'b001,
    RSF_LINK_SEND = 3'b010,
    RSF_LINK_REST = 3'b100
  } rsf_link_state_type;

endpackage : rsf_pkg

// [src/rsf_status_flags.sv]
// Summary of operation
// - presence bits in input order in the low byte, bit 7 always 0
// - flags in bits 8..15: error, change, rate, status, non-pcm, pc, gp, emphasis
// - error flag follows the error source selection, 1 on unlock, or on error or unlock with select low
// - input change flag set on any presence change, cleared after readout
// - rate update flag set on each new rate result, cleared after readout
// - channel status update flag set on new 48-bit capture, cleared after readout
// - pc update flag set on new burst pc word, cleared after readout
// - parallel input flag set on gp data change in parallel mode only
// - non-pcm flag is the live audio status, never latched
// - emphasis flag is the live emphasis indication at readout
// - bit 16 carries channel status bit 1, 0 pcm, 1 non-pcm
// - bit 17 set while burst preambles pa and pb are detected
// - bit 18 set while the 5.1 channel sync pattern is detected
// - bit 19 set on 6.1 channel sync pattern, bits 20..23 read 0
module rsf_status_flags
  import rsf_pkg::*;
(
  input  wire logic                   SYS_CLK,
  input  wire logic                   SYS_RST,
  input  wire logic                   CTL_CLK,
  input  wire logic                   CTL_SEL,
  input  wire logic                   CTL_DI,
  output logic                        CTL_DO,
  output logic                        CTL_DO_OE_N,
  input  wire logic [RSF_INPUTS-1:0]  INPUT_PRESENT,
  input  wire logic                   TRANSFER_ERROR,
  input  wire logic                   PLL_UNLOCKED,
  input  wire logic                   ERROR_SOURCE_SELECT,
  input  wire logic                   NON_PCM_DETECT,
  input  wire logic                   RATE_UPDATED,
  input  wire logic                   CHAN_STATUS_UPDATED,
  input  wire logic                   PC_UPDATED,
  input  wire logic                   GP_PIN_FUNCTION_SELECT,
  input  wire logic [RSF_GP_BITS-1:0] GP_DATA,
  input  wire logic                   EMPHASIS_DETECT,
  input  wire logic                   PCM_MODE_BIT,
  input  wire logic                   BURST_PREAMBLE_SEEN,
  input  wire logic                   SYNC51_SEEN,
  input  wire logic                   SYNC61_SEEN
);

  // ==========================================================================
  // system domain declarations
  // ==========================================================================
  logic [RSF_GP_BITS-1:0] gp_meta_reg;
  logic [RSF_GP_BITS-1:0] gp_sync_reg;
  logic [RSF_GP_BITS-1:0] gp_prev_reg;
  logic                   sel_meta_reg;
  logic                   sel_sync_reg;
  logic                   sel_prev_reg;
  logic                   done_meta_reg;
  logic                   done_sync_reg;
  logic                   done_prev_reg;
  logic [RSF_INPUTS-1:0]  present_prev_reg;
  logic [RSF_EVENTS-1:0]  evt;
  logic [RSF_EVENTS-1:0]  sticky_reg;
  logic [RSF_EVENTS-1:0]  seen_reg;
  logic [RSF_EVENTS-1:0]  snap_ev;
  logic                   clear_pulse;
  logic                   rx_err;
  rsf_status_type         live;
  rsf_status_type         snap_reg;

  // ==========================================================================
  // link domain declarations
  // ==========================================================================
  logic                     lrst_meta_reg;
  logic                     lrst_sync_reg;
  logic [RSF_ADDR_BITS-1:0] addr_reg;
  logic [3:0]               addr_cnt_reg;
  logic                     addr_hit;
  rsf_link_state_type       link_state_reg;
  logic [RSF_WORD_BITS-1:0] shift_reg;
  logic [4:0]               bit_cnt_reg;
  logic                     done_tgl_reg;
  logic                     do_reg;
  logic                     do_oe_n_reg;

  // ==========================================================================
  // synchronisers into the system domain
  // ==========================================================================
  // gp pins are asynchronous; the select pin marks the read window and
  // the done toggle reports a completed word from the link side
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      gp_meta_reg   <= '0;
      gp_sync_reg   <= '0;
      gp_prev_reg   <= '0;
      sel_meta_reg  <= 1'b0;
      sel_sync_reg  <= 1'b0;
      sel_prev_reg  <= 1'b0;
      done_meta_reg <= 1'b0;
      done_sync_reg <= 1'b0;
      done_prev_reg <= 1'b0;
    end else begin
      gp_meta_reg   <= GP_DATA;
      gp_sync_reg   <= gp_meta_reg;
      gp_prev_reg   <= gp_sync_reg;
      sel_meta_reg  <= CTL_SEL;
      sel_sync_reg  <= sel_meta_reg;
      sel_prev_reg  <= sel_sync_reg;
      done_meta_reg <= done_tgl_reg;
      done_sync_reg <= done_meta_reg;
      done_prev_reg <= done_sync_reg;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      present_prev_reg <= '0;
    end else begin
      present_prev_reg <= INPUT_PRESENT;
    end
  end

  assign clear_pulse  = done_sync_reg ^ done_prev_reg;

  // ==========================================================================
  // event detection
  // ==========================================================================
  always_comb begin
    evt                = '0;
    evt[RSF_EV_IN_CHG] = (INPUT_PRESENT != present_prev_reg);
    evt[RSF_EV_RATE]   = RATE_UPDATED;
    evt[RSF_EV_CS]     = CHAN_STATUS_UPDATED;
    evt[RSF_EV_PC]     = PC_UPDATED;
    // selector mode reuses the gp pins, so their changes mean nothing there
    evt[RSF_EV_GP]     = ~GP_PIN_FUNCTION_SELECT & (gp_sync_reg != gp_prev_reg);
  end

  // select high means unlock only; low adds transfer errors while locked
  assign rx_err = ERROR_SOURCE_SELECT ? PLL_UNLOCKED
                                      : (TRANSFER_ERROR | PLL_UNLOCKED);

  assign snap_ev = {snap_reg.parallel_input_update_flag, snap_reg.pc_update_flag,
                    snap_reg.chan_status_update_flag, snap_reg.rate_update_flag,
                    snap_reg.input_change_flag};

  // ==========================================================================
  // read-to-clear flags
  // ==========================================================================
  // a flag is cleared only if the host actually saw it set and nothing new
  // arrived since the snapshot; a fresh event always wins over the clear
  generate
    for (genvar i = 0; i < RSF_EVENTS; i++) begin : g_flag
      always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
          seen_reg[i] <= 1'b0;
        end else if (!sel_sync_reg) begin
          // restarts on every open edge, so the snapshot's last edge is covered
          seen_reg[i] <= evt[i];
        end else if (evt[i]) begin
          seen_reg[i] <= 1'b1;
        end
      end

      always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
          sticky_reg[i] <= 1'b0;
        end else if (evt[i]) begin
          sticky_reg[i] <= 1'b1;
        end else if (clear_pulse && snap_ev[i] && !seen_reg[i]) begin
          sticky_reg[i] <= 1'b0;
        end
      end
    end
  endgenerate

  // ==========================================================================
  // status word assembly and snapshot
  // ==========================================================================
  always_comb begin
    live                            = RSF_STATUS_RESET;
    live.input_present              = INPUT_PRESENT;
    live.zero_b7                    = 1'b0;
    live.receive_error_flag         = rx_err;
    live.input_change_flag          = sticky_reg[RSF_EV_IN_CHG];
    live.rate_update_flag           = sticky_reg[RSF_EV_RATE];
    live.chan_status_update_flag    = sticky_reg[RSF_EV_CS];
    live.non_pcm_flag               = NON_PCM_DETECT;
    live.pc_update_flag             = sticky_reg[RSF_EV_PC];
    live.parallel_input_update_flag = sticky_reg[RSF_EV_GP];
    live.emphasis_flag              = EMPHASIS_DETECT;
    live.pcm_mode_bit               = PCM_MODE_BIT;
    live.burst_preamble_seen        = BURST_PREAMBLE_SEEN;
    live.sync51_seen                = SYNC51_SEEN;
    live.sync61_seen                = SYNC61_SEEN;
    live.zero_hi                    = '0;
  end

  // the snapshot is quasi-static while the select pin is high, which is what
  // lets the link side load it without a word-wide synchroniser
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      snap_reg <= RSF_STATUS_RESET;
    end else if (!sel_sync_reg) begin
      snap_reg <= live;
    end
  end

  // ==========================================================================
  // link domain: reset and address phase
  // ==========================================================================
  // the host clock may stop between frames; reset needs link edges to land
  always_ff @(posedge CTL_CLK) begin
    lrst_meta_reg <= SYS_RST;
    lrst_sync_reg <= lrst_meta_reg;
  end

  always_ff @(posedge CTL_CLK) begin
    if (lrst_sync_reg) begin
      addr_reg     <= '0;
      addr_cnt_reg <= '0;
    end else if (!CTL_SEL) begin
      addr_reg <= {CTL_DI, addr_reg[RSF_ADDR_BITS-1:1]};
      if (addr_cnt_reg != RSF_ADDR_FULL) begin
        addr_cnt_reg <= addr_cnt_reg + 4'h1;
      end
    end else begin
      addr_cnt_reg <= '0;
    end
  end

  assign addr_hit = (addr_cnt_reg == RSF_ADDR_FULL) && (addr_reg == RSF_ADDR_FLAGS);

  // ==========================================================================
  // link domain: data phase
  // ==========================================================================
  always_ff @(posedge CTL_CLK) begin
    if (lrst_sync_reg || !CTL_SEL) begin
      link_state_reg <= RSF_LINK_ADDR;
    end else begin
      case (link_state_reg)
        RSF_LINK_ADDR: begin
          link_state_reg <= addr_hit ? RSF_LINK_SEND : RSF_LINK_REST;
        end
        RSF_LINK_SEND: begin
          if (bit_cnt_reg == RSF_LAST_SHIFT) begin
            link_state_reg <= RSF_LINK_REST;
          end
        end
        RSF_LINK_REST: begin
          link_state_reg <= RSF_LINK_REST;
        end
        default: begin
          link_state_reg <= RSF_LINK_ADDR;
        end
      endcase
    end
  end

  always_ff @(posedge CTL_CLK) begin
    if (lrst_sync_reg || !CTL_SEL) begin
      shift_reg   <= '0;
      bit_cnt_reg <= RSF_BIT_FIRST;
      do_reg      <= 1'b0;
      do_oe_n_reg <= 1'b1;
    end else if (link_state_reg == RSF_LINK_ADDR && addr_hit) begin
      shift_reg   <= {1'b0, snap_reg[RSF_WORD_BITS-1:1]};
      do_reg      <= snap_reg[0];
      do_oe_n_reg <= 1'b0;
      bit_cnt_reg <= RSF_BIT_FIRST;
    end else if (link_state_reg == RSF_LINK_SEND) begin
      shift_reg   <= {1'b0, shift_reg[RSF_WORD_BITS-1:1]};
      do_reg      <= shift_reg[0];
      bit_cnt_reg <= bit_cnt_reg + RSF_BIT_STEP;
    end
  end

  // toggles only when the last bit goes out; an aborted word clears nothing
  always_ff @(posedge CTL_CLK) begin
    if (lrst_sync_reg) begin
      done_tgl_reg <= 1'b0;
    end else if (CTL_SEL && link_state_reg == RSF_LINK_SEND
                 && bit_cnt_reg == RSF_LAST_SHIFT) begin
      done_tgl_reg <= ~done_tgl_reg;
    end
  end

  assign CTL_DO      = do_reg;
  assign CTL_DO_OE_N = do_oe_n_reg;

  // ==========================================================================
  // assertions: system domain
  // ==========================================================================
  zero_bits_a: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    !snap_reg.zero_b7 && snap_reg.zero_hi == 4'h0)
    else $error("reserved status bits not zero");

  presence_copy_a: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    !sel_sync_reg |=> snap_reg.input_present == $past(INPUT_PRESENT))
    else $error("presence bits do not follow inputs");

  live_copy_a: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    !sel_sync_reg |=> (snap_reg.non_pcm_flag == $past(NON_PCM_DETECT))
      && (snap_reg.emphasis_flag == $past(EMPHASIS_DETECT))
      && (snap_reg.receive_error_flag == $past(rx_err))
      && (snap_reg.pcm_mode_bit == $past(PCM_MODE_BIT))
      && (snap_reg.sync61_seen == $past(SYNC61_SEEN)))
    else $error("live status bits not copied");

  change_set_a: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    (INPUT_PRESENT != present_prev_reg) |=> sticky_reg[RSF_EV_IN_CHG])
    else $error("input change flag not set");

  set_wins_a: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    RATE_UPDATED |=> sticky_reg[RSF_EV_RATE])
    else $error("rate update lost against clear");

  gp_mode_a: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    $rose(sticky_reg[RSF_EV_GP]) |-> $past(!GP_PIN_FUNCTION_SELECT))
    else $error("gp flag set in selector mode");

  late_event_a: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    (clear_pulse && seen_reg[RSF_EV_CS]) |=> sticky_reg[RSF_EV_CS])
    else $error("event during read was cleared");

  snap_hold_a: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    (sel_sync_reg && sel_prev_reg) |=> $stable(snap_reg))
    else $error("snapshot changed during read");

  // ==========================================================================
  // assertions: link domain
  // ==========================================================================
  sequence word_load_s;
    CTL_SEL && link_state_reg == RSF_LINK_ADDR && addr_hit;
  endsequence

  sequence word_body_s;
    word_load_s ##1 CTL_SEL [*8] ##1 CTL_SEL [*8] ##1 CTL_SEL [*7];
  endsequence

  first_bit_a: assert property (@(posedge CTL_CLK) disable iff (lrst_sync_reg)
    word_load_s |=> !CTL_DO_OE_N && CTL_DO == $past(snap_reg[0]))
    else $error("first bit is not status bit 0");

  word_done_a: assert property (@(posedge CTL_CLK) disable iff (lrst_sync_reg)
    word_body_s |=> $changed(done_tgl_reg))
    else $error("done not reported after 24 bits");

  abort_quiet_a: assert property (@(posedge CTL_CLK) disable iff (lrst_sync_reg)
    !CTL_SEL |=> $stable(done_tgl_reg) && CTL_DO_OE_N)
    else $error("aborted read reported done or drove pin");

endmodule : rsf_status_flags

// [verif/rsf_host_model.sv]
module rsf_host_model
  import rsf_pkg::*;
(
  output logic      ctl_clk,
  output logic      ctl_sel,
  output logic      ctl_di,
  input  wire logic ctl_do,
  input  wire logic ctl_do_oe_n
);
  timeunit 1ns;
  timeprecision 100ps;

  logic last_bit;
  logic line;

  // a released data line must not look like a held bit, so show its inverse
  assign line = ctl_do_oe_n ? ~last_bit : ctl_do;

  initial begin
    ctl_clk  = 1'b0;
    ctl_sel  = 1'b0;
    ctl_di   = 1'b0;
    last_bit = 1'b0;
  end

  always @(posedge ctl_clk) begin
    if (!ctl_do_oe_n) begin
      last_bit <= ctl_do;
    end
  end

  // ==========================================================================
  // link clock: 80 ns, runs only inside frames and idle calls, off the system clock grid
  // ==========================================================================
  task automatic tick();
    #39.3 ctl_clk = 1'b1;
    #40.7 ctl_clk = 1'b0;
  endtask : tick

  task automatic idle(input int n);
    repeat (n) tick();
  endtask : idle

  // address lsb first, then select high; a long setup_ns makes a slow host
  task automatic read_word(
    input  logic [7:0]     addr,
    input  int             nbits,
    input  int             setup_ns,
    output rsf_status_type word,
    output logic [23:0]    drv_cnt,
    output logic           released
  );
    logic [23:0] w;
    w       = 24'h000000;
    drv_cnt = 24'h000000;
    ctl_sel = 1'b0;
    for (int i = 0; i < RSF_ADDR_BITS; i++) begin
      ctl_di = addr[i];
      tick();
    end
    ctl_di  = 1'b0;
    ctl_sel = 1'b1;
    #(setup_ns);
    for (int i = 0; i < nbits; i++) begin
      tick();
      w[i]    = line;
      drv_cnt = drv_cnt + {23'h000000, ~ctl_do_oe_n};
    end
    ctl_sel = 1'b0;
    tick();
    released = ctl_do_oe_n;
    word     = w;
    #300;
  endtask : read_word
endmodule : rsf_host_model

// [verif/tb_top.sv]
module tb_top
  import rsf_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic       sys_clk, sys_rst, xfer_err, pll_unl, esel, non_pcm, rate_up, cs_up, pc_up;
  logic       gp_sel, emph, pcm_bit, burst, s51, s61;
  logic [6:0] in_pres;
  logic [3:0] gp_data;
  logic [4:0] ev, ev_late;
  wire        ctl_clk, ctl_sel, ctl_di, ctl_do, ctl_do_oe_n;
  int         error_cnt, checks_done;

  always #2.5 sys_clk = ~sys_clk;

  rsf_status_flags i_rsf_status_flags (.SYS_CLK(sys_clk), .SYS_RST(sys_rst),
    .CTL_CLK(ctl_clk), .CTL_SEL(ctl_sel), .CTL_DI(ctl_di), .CTL_DO(ctl_do),
    .CTL_DO_OE_N(ctl_do_oe_n), .INPUT_PRESENT(in_pres), .TRANSFER_ERROR(xfer_err),
    .PLL_UNLOCKED(pll_unl), .ERROR_SOURCE_SELECT(esel), .NON_PCM_DETECT(non_pcm),
    .RATE_UPDATED(rate_up), .CHAN_STATUS_UPDATED(cs_up), .PC_UPDATED(pc_up),
    .GP_PIN_FUNCTION_SELECT(gp_sel), .GP_DATA(gp_data), .EMPHASIS_DETECT(emph),
    .PCM_MODE_BIT(pcm_bit), .BURST_PREAMBLE_SEEN(burst), .SYNC51_SEEN(s51),
    .SYNC61_SEEN(s61));

  rsf_host_model i_rsf_host_model (.ctl_clk(ctl_clk), .ctl_sel(ctl_sel), .ctl_di(ctl_di),
    .ctl_do(ctl_do), .ctl_do_oe_n(ctl_do_oe_n));

  // ==========================================================================
  // checking and reference
  // ==========================================================================
  task automatic check(input logic [23:0] seen, input logic [23:0] exp, input string what);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %0t %s: seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : tally_and_finish

  function automatic rsf_status_type exp_word();
    rsf_status_type e;
    e = RSF_STATUS_RESET;
    e.input_present              = in_pres;
    e.receive_error_flag         = esel ? pll_unl : (xfer_err | pll_unl);
    e.input_change_flag          = ev[RSF_EV_IN_CHG];
    e.rate_update_flag           = ev[RSF_EV_RATE];
    e.chan_status_update_flag    = ev[RSF_EV_CS];
    e.pc_update_flag             = ev[RSF_EV_PC];
    e.parallel_input_update_flag = ev[RSF_EV_GP];
    e.non_pcm_flag               = non_pcm;
    e.emphasis_flag              = emph;
    e.pcm_mode_bit               = pcm_bit;
    e.burst_preamble_seen        = burst;
    e.sync51_seen                = s51;
    e.sync61_seen                = s61;
    return e;
  endfunction : exp_word

  // a short frame must leave every flag standing, so only full frames clear the model
  task automatic do_read(input int nbits, input int setup_ns, input string what);
    rsf_status_type e, w;
    logic [23:0]    cnt;
    logic           rel;
    logic [4:0]     snap;
    e       = exp_word();
    snap    = ev;
    ev_late = 5'h00;
    i_rsf_host_model.read_word(RSF_ADDR_FLAGS, nbits, setup_ns, w, cnt, rel);
    check(cnt, 24'(nbits), {what, " drive"});
    check({23'h000000, rel}, 24'h000001, {what, " release"});
    if (nbits == RSF_WORD_BITS) begin
      check(w, e, what);
      // an event landing during the frame keeps its flag for the next read
      ev = (ev & ~snap) | ev_late;
    end
  endtask : do_read

  task automatic set_pres(input logic [6:0] v);
    @(posedge sys_clk);
    if (v != in_pres) begin
      ev[RSF_EV_IN_CHG]      = 1'b1;
      ev_late[RSF_EV_IN_CHG] = 1'b1;
    end
    in_pres <= v;
  endtask : set_pres

  task automatic event_in(input int k);
    @(posedge sys_clk);
    case (k)
      RSF_EV_RATE: rate_up <= 1'b1;
      RSF_EV_CS:   cs_up <= 1'b1;
      RSF_EV_PC:   pc_up <= 1'b1;
      default:     gp_data <= gp_data + 4'h1;
    endcase
    ev[k]      = 1'b1;
    ev_late[k] = 1'b1;
    @(posedge sys_clk);
    {rate_up, cs_up, pc_up} <= 3'h0;
    repeat (8) @(posedge sys_clk);
  endtask : event_in

  // ==========================================================================
  // scenarios
  // ==========================================================================
  task automatic t_live();
    for (int k = 0; k < 7; k++) begin
      set_pres(7'h7F ^ 7'(1 << k));
      {s61, s51, burst, pcm_bit, emph, non_pcm} <= 6'(1 << k);
      repeat (4) @(posedge sys_clk);
      do_read(24, 40, "live set");
      do_read(24, 400, "live again");
    end
  endtask : t_live

  task automatic t_error();
    for (int k = 0; k < 8; k++) begin
      @(posedge sys_clk);
      {esel, xfer_err, pll_unl} <= 3'(k);
      repeat (4) @(posedge sys_clk);
      do_read(24, 40, "error source");
    end
  endtask : t_error

  task automatic t_events();
    for (int k = RSF_EV_RATE; k <= RSF_EV_GP; k++) begin
      event_in(k);
      do_read(24, 40, "event set");
      do_read(24, 40, "event clear");
    end
    @(posedge sys_clk);
    gp_sel <= 1'b1;
    repeat (4) @(posedge sys_clk);
    gp_data <= ~gp_data;
    repeat (8) @(posedge sys_clk);
    do_read(24, 40, "selector mode");
    @(posedge sys_clk);
    gp_sel <= 1'b0;
    repeat (8) @(posedge sys_clk);
  endtask : t_events

  task automatic t_abort();
    rsf_status_type w;
    logic [23:0]    cnt;
    logic           rel;
    event_in(RSF_EV_PC);
    i_rsf_host_model.read_word(8'hEB, 24, 40, w, cnt, rel);
    check(cnt, 24'h000000, "other address drive");
    do_read(12, 40, "short frame");
    event_in(RSF_EV_RATE);
    do_read(24, 40, "after short");
    // the flag is already set in the snapshot, so only the late event keeps it
    event_in(RSF_EV_CS);
    fork
      do_read(24, 40, "event mid read");
      begin
        #1500;
        event_in(RSF_EV_CS);
      end
    join
    do_read(24, 40, "event kept");
  endtask : t_abort

  initial begin
    sys_clk = 1'b0;
    sys_rst = 1'b1;
    {xfer_err, pll_unl, esel, non_pcm, rate_up, cs_up, pc_up, gp_sel} = 8'h00;
    {emph, pcm_bit, burst, s51, s61, in_pres, gp_data} = 16'h0000;
    ev          = 5'h00;
    ev_late     = 5'h00;
    error_cnt   = 0;
    checks_done = 0;
    // the link side resets from its own clock, so tick it during reset
    fork
      repeat (5) @(posedge sys_clk);
      i_rsf_host_model.idle(4);
    join
    @(posedge sys_clk);
    sys_rst <= 1'b0;
    i_rsf_host_model.idle(4);
    check({23'h000000, ctl_do_oe_n}, 24'h000001, "idle release");
    do_read(24, 40, "after reset");
    t_live();
    t_error();
    t_events();
    t_abort();
    tally_and_finish();
  end

  initial begin
    #400000;
    error_cnt++;
    $display("[ERR] %0t watchdog expired", $time);
    tally_and_finish();
  end
endmodule : tb_top
